// ===== verilog/cc_pkg.sv
// Constants and types shared by the comparator control block
package cc_pkg;

    // Chip variants, which differ in field layout
    typedef enum logic [1:0] {
        CC_BASE,
        CC_LOWV,
        CC_SMALL
    } cc_variant_e;

    // Source of a comparator's non-inverting input
    typedef enum logic [1:0] {
        CC_SRC_PIN,
        CC_SRC_LADDER,
        CC_SRC_FIXED
    } cc_src_e;

    // Register byte offsets
    localparam logic [7:0] CC_OFS_CONFIG = 8'h00;
    localparam logic [7:0] CC_OFS_REF = 8'h04;
    localparam logic [7:0] CC_OFS_RESULT = 8'h08;
    localparam logic [7:0] CC_OFS_FLAG = 8'h0C;

    // Configuration word fields
    localparam int CC_CFG_W = 10;
    localparam int CC_CFG_EN1 = 0;
    localparam int CC_CFG_EN2 = 1;
    localparam int CC_CFG_INV1 = 2;
    localparam int CC_CFG_INV2 = 3;
    localparam int CC_CFG_CHG1 = 4;
    localparam int CC_CFG_CHG2 = 5;
    localparam int CC_CFG_INT1 = 6;
    localparam int CC_CFG_INT2 = 7;
    localparam int CC_CFG_FIX1 = 8;
    localparam int CC_CFG_FIX2 = 9;
    localparam logic [9:0] CC_CFG_RST = 10'h000;
    localparam logic [9:0] CC_CFG_MASK_BASE = 10'h05F;
    localparam logic [9:0] CC_CFG_MASK_LOWV = 10'h3FF;
    localparam logic [9:0] CC_CFG_MASK_SMALL = 10'h3BF;

    // Reference byte fields
    localparam int CC_REF_LADDER_EN = 7;
    localparam int CC_REF_SHORT = 5;
    localparam logic [7:0] CC_REF_RST = 8'h00;
    localparam logic [7:0] CC_REF_MASK_LARGE = 8'hAF;
    localparam logic [7:0] CC_REF_MASK_SMALL = 8'h9F;

    // Ladder: taps in 32nds of supply, bottom resistor adds a quarter
    localparam int CC_LADDER_STEPS = 32;
    localparam logic [5:0] CC_LADDER_BOTTOM = 6'h08;
    localparam int CC_BOTTOM_RATIO = 8;

    // Fixed references in millivolts
    localparam logic [10:0] CC_FIXED_LOWV_MV = 11'h4B0;
    localparam logic [10:0] CC_FIXED_SMALL_MV = 11'h400;

    // Flag register
    localparam int CC_FLAG_CHANGE = 0;

    // Bundle towards the analogue macro
    typedef struct packed {
        logic cmp1_enable;
        logic cmp2_enable;
        cc_src_e cmp1_src;
        cc_src_e cmp2_src;
        logic ladder_enable;
        logic ladder_short;
        logic [4:0] ladder_tap;
        logic [5:0] ladder_level;
        logic [10:0] fixed_mv;
    } cc_ana_s;

endpackage

// ===== verilog/cc_comparator_control.sv
// Comparator control: APB registers, input muxing, result and change flag
// Functional notes
// - Config bit 0 enables comparator one
// - Bit 1: both on base, else comparator two
// - Bits 2,3 invert each reported output
// - Result bit0 comparator one, bit1 two
// - Base: bit 4 flags either change
// - Other variants: bits 4,5 per comparator
// - Enabled change sets flag, usable for interrupt
// - Enabled change wakes device from sleep
// - Base bit 6: pins or ladder
// - Low-voltage bits 6,7: pin or internal
// - Low-voltage bits 8,9: ladder or 1.2V
// - Small bits 8,9 select 1.024V reference
// - Reference bit 7 enables the ladder
// - Larger variants: bit 5 shorts bottom resistor
// - Larger variants: bits 3:0 pick 16 taps
// - Small variant: bits 4:0 pick 32 taps
// - Level is tap/32, plus quarter supply on larger variants unless shorted
// - Bottom resistor is eight unit resistors
`timescale 1ns/100ps
`default_nettype none
module cc_comparator_control
    import cc_pkg::*;
#(
    parameter cc_variant_e VARIANT = CC_BASE
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] cmp_raw,
    input wire logic sleep_active,
    output cc_ana_s ana_ctrl,
    output logic [1:0] cmp_result,
    output logic change_flag,
    output logic wake_req
);

    // Writable bits per variant; reserved bits are never stored
    function automatic logic [9:0] cfg_mask(input cc_variant_e v);
        unique case (v)
            CC_BASE: cfg_mask = CC_CFG_MASK_BASE;
            CC_LOWV: cfg_mask = CC_CFG_MASK_LOWV;
            CC_SMALL: cfg_mask = CC_CFG_MASK_SMALL;
        endcase
    endfunction

    function automatic logic [7:0] ref_mask(input cc_variant_e v);
        unique case (v)
            CC_SMALL: ref_mask = CC_REF_MASK_SMALL;
            CC_BASE, CC_LOWV: ref_mask = CC_REF_MASK_LARGE;
        endcase
    endfunction

    // Input source from the pin/internal bit and the fixed bit
    function automatic cc_src_e pick_src(input logic internal,
                                         input logic fixed);
        if (!internal) begin
            pick_src = CC_SRC_PIN;
        end else if (fixed) begin
            pick_src = CC_SRC_FIXED;
        end else begin
            pick_src = CC_SRC_LADDER;
        end
    endfunction

    logic [9:0] cfg_reg;
    logic [7:0] ref_reg;
    logic flag_reg;
    logic [31:0] rdata_reg;
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] prev_reg;
    logic prev_valid_reg;
    logic wake_reg;
    logic [1:0] cmp_on;
    logic [1:0] result_next;
    logic [1:0] mon_mask;
    logic change_ev;
    logic setup_ph;
    logic access_ph;
    logic addr_hit;
    logic wr_cfg;
    logic wr_ref;
    logic clr_flag;
    logic [31:0] rd_mux;

    // APB phase decode; the slave never inserts wait states
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign addr_hit = (paddr == CC_OFS_CONFIG) || (paddr == CC_OFS_REF) ||
                      (paddr == CC_OFS_RESULT) || (paddr == CC_OFS_FLAG);
    assign pready = 1'b1;
    assign pslverr = access_ph && !addr_hit;
    assign wr_cfg = access_ph && pwrite && (paddr == CC_OFS_CONFIG);
    assign wr_ref = access_ph && pwrite && (paddr == CC_OFS_REF);
    assign clr_flag = access_ph && pwrite && (paddr == CC_OFS_FLAG) &&
                      pwdata[CC_FLAG_CHANGE];

    // Configuration word; base bits 5 and 7 read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= CC_CFG_RST;
        end else if (wr_cfg) begin
            cfg_reg <= pwdata[CC_CFG_W-1:0] & cfg_mask(VARIANT);
        end
    end

    // Reference byte; tap width depends on variant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_reg <= CC_REF_RST;
        end else if (wr_ref) begin
            ref_reg <= pwdata[7:0] & ref_mask(VARIANT);
        end
    end

    // Read data captured in the setup cycle so prdata is a flop
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            CC_OFS_CONFIG: rd_mux[CC_CFG_W-1:0] = cfg_reg;
            CC_OFS_REF: rd_mux[7:0] = ref_reg;
            CC_OFS_RESULT: rd_mux[1:0] = result_next;
            CC_OFS_FLAG: rd_mux[CC_FLAG_CHANGE] = flag_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            rdata_reg <= rd_mux;
        end
    end
    assign prdata = rdata_reg;

    // Comparator enables; base bit 1 turns both on
    always_comb begin
        cmp_on[0] = cfg_reg[CC_CFG_EN1];
        cmp_on[1] = cfg_reg[CC_CFG_EN2];
        if (VARIANT == CC_BASE) begin
            cmp_on[0] = cfg_reg[CC_CFG_EN1] || cfg_reg[CC_CFG_EN2];
        end
    end

    // Two-stage synchroniser on the asynchronous analogue outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
        end else begin
            sync1_reg <= cmp_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // Reported value: inverted as if inputs swapped, zero when off
    function automatic logic [1:0] sync_result();
        sync_result[0] = cmp_on[0] &&
                         (sync2_reg[0] ^ cfg_reg[CC_CFG_INV1]);
        sync_result[1] = cmp_on[1] &&
                         (sync2_reg[1] ^ cfg_reg[CC_CFG_INV2]);
    endfunction

    // Procedural call: a bare assign of a no-argument call never re-runs
    always_comb begin
        result_next = sync_result();
    end

    // Result output held in flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_result <= 2'h0;
        end else begin
            cmp_result <= result_next;
        end
    end

    // Which comparators are watched for changes
    always_comb begin
        if (VARIANT == CC_BASE) begin
            mon_mask = {2{cfg_reg[CC_CFG_CHG1]}};
        end else begin
            mon_mask = {cfg_reg[CC_CFG_CHG2], cfg_reg[CC_CFG_CHG1]};
        end
    end
    // per-comparator masking is the else branch

    // Previous value; the first sample after reset is not a change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 2'h0;
            prev_valid_reg <= 1'b0;
        end else begin
            prev_reg <= result_next;
            prev_valid_reg <= 1'b1;
        end
    end

    // Toggling invert or enable also counts: the reported value moved
    assign change_ev = prev_valid_reg &&
                       |((prev_reg ^ result_next) & mon_mask);

    // Sticky flag; a change in the clear cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
        end else if (change_ev) begin
            flag_reg <= 1'b1;
        end else if (clr_flag) begin
            flag_reg <= 1'b0;
        end
    end
    assign change_flag = flag_reg;

    // Wake pulse only while the core sleeps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= change_ev && sleep_active;
        end
    end
    assign wake_req = wake_reg;

    // Analogue control bundle
    always_comb begin
        ana_ctrl = '0;
        ana_ctrl.cmp1_enable = cmp_on[0];
        ana_ctrl.cmp2_enable = cmp_on[1];
        ana_ctrl.ladder_enable = ref_reg[CC_REF_LADDER_EN];
        unique case (VARIANT)
            CC_BASE: begin
                // Pins 3 and 2, or both on ladder
                ana_ctrl.cmp1_src = cfg_reg[CC_CFG_INT1] ?
                                    CC_SRC_LADDER : CC_SRC_PIN;
                ana_ctrl.cmp2_src = ana_ctrl.cmp1_src;
                ana_ctrl.fixed_mv = 11'h000;
            end
            CC_LOWV: begin
                ana_ctrl.cmp1_src = pick_src(cfg_reg[CC_CFG_INT1],
                                             cfg_reg[CC_CFG_FIX1]);
                ana_ctrl.cmp2_src = pick_src(cfg_reg[CC_CFG_INT2],
                                             cfg_reg[CC_CFG_FIX2]);
                ana_ctrl.fixed_mv = CC_FIXED_LOWV_MV;
            end
            CC_SMALL: begin
                // Comparator one has no pin choice here
                ana_ctrl.cmp1_src = pick_src(1'b1, cfg_reg[CC_CFG_FIX1]);
                ana_ctrl.cmp2_src = pick_src(cfg_reg[CC_CFG_INT2],
                                             cfg_reg[CC_CFG_FIX2]);
                ana_ctrl.fixed_mv = CC_FIXED_SMALL_MV;
            end
        endcase
        if (VARIANT == CC_SMALL) begin
            ana_ctrl.ladder_tap = ref_reg[4:0];
            ana_ctrl.ladder_short = 1'b1;
            ana_ctrl.ladder_level = {1'b0, ref_reg[4:0]};
        end else begin
            ana_ctrl.ladder_tap = {1'b0, ref_reg[3:0]};
            ana_ctrl.ladder_short = ref_reg[CC_REF_SHORT];
            // Bottom 8-unit resistor lifts level by 8/32
            ana_ctrl.ladder_level = {2'b00, ref_reg[3:0]} +
                (ref_reg[CC_REF_SHORT] ? 6'h00 : CC_LADDER_BOTTOM);
        end
        // Level in 32nds of supply
    end

    // Enable follows config bit 0
    property p_en1;
        @(posedge pclk) disable iff (!presetn)
        (cfg_reg[CC_CFG_EN1] |-> ana_ctrl.cmp1_enable);
    endproperty
    a_en1: assert property (p_en1)
        else $error("comparator one not enabled");

    property p_en2_base;
        @(posedge pclk) disable iff (!presetn)
        (VARIANT == CC_BASE && cfg_reg[CC_CFG_EN2]) |->
            (ana_ctrl.cmp1_enable && ana_ctrl.cmp2_enable);
    endproperty
    a_en2_base: assert property (p_en2_base)
        else $error("base bit 1 did not enable both");

    property p_invert;
        @(posedge pclk) disable iff (!presetn)
        cmp_on[0] |=>
            (cmp_result[0] ==
             ($past(sync2_reg[0]) ^ $past(cfg_reg[CC_CFG_INV1])));
    endproperty
    a_invert: assert property (p_invert)
        else $error("comparator one result wrong");

    property p_off_zero;
        @(posedge pclk) disable iff (!presetn)
        (!cmp_on[1]) |=> (cmp_result[1] == 1'b0);
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("disabled comparator reads nonzero");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        change_ev |=> change_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("change did not set flag");

    property p_flag_sticky;
        @(posedge pclk) disable iff (!presetn)
        (change_flag && !clr_flag) |=> change_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without clear");

    property p_no_mon;
        @(posedge pclk) disable iff (!presetn)
        (mon_mask == 2'h0) |-> !change_ev;
    endproperty
    a_no_mon: assert property (p_no_mon)
        else $error("change flagged while disabled");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        (change_ev && sleep_active) |=> wake_req ##1
            (wake_req == $past(change_ev && sleep_active));
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake pulse missing");

    property p_level;
        @(posedge pclk) disable iff (!presetn)
        (VARIANT != CC_SMALL && !ref_reg[CC_REF_SHORT]) |->
            (ana_ctrl.ladder_level == {2'b00, ref_reg[3:0]} + 6'h08);
    endproperty
    a_level: assert property (p_level)
        else $error("ladder level wrong");

    property p_ladder_en;
        @(posedge pclk) disable iff (!presetn)
        wr_ref |=> (ana_ctrl.ladder_enable ==
                    $past(pwdata[CC_REF_LADDER_EN]));
    endproperty
    a_ladder_en: assert property (p_ladder_en)
        else $error("ladder enable not taken");

    // Unwatched comparator one cannot raise a change on its own
    property p_mon_sep;
        @(posedge pclk) disable iff (!presetn)
        (VARIANT != CC_BASE && !cfg_reg[CC_CFG_CHG1] &&
         (prev_reg[1] == result_next[1])) |-> !change_ev;
    endproperty
    a_mon_sep: assert property (p_mon_sep)
        else $error("unwatched comparator flagged");

    property p_src_base;
        @(posedge pclk) disable iff (!presetn)
        (VARIANT == CC_BASE) |->
            (ana_ctrl.cmp2_src == ana_ctrl.cmp1_src &&
             ana_ctrl.cmp1_src == (cfg_reg[CC_CFG_INT1] ?
                                   CC_SRC_LADDER : CC_SRC_PIN));
    endproperty
    a_src_base: assert property (p_src_base)
        else $error("base input source wrong");

    property p_fixed_small;
        @(posedge pclk) disable iff (!presetn)
        (VARIANT == CC_SMALL && cfg_reg[CC_CFG_FIX1]) |->
            (ana_ctrl.cmp1_src == CC_SRC_FIXED &&
             ana_ctrl.fixed_mv == CC_FIXED_SMALL_MV);
    endproperty
    a_fixed_small: assert property (p_fixed_small)
        else $error("small fixed reference not chosen");

    // No bottom resistor on the small part: level is the tap itself
    property p_tap_small;
        @(posedge pclk) disable iff (!presetn)
        (VARIANT == CC_SMALL) |->
            (ana_ctrl.ladder_level == {1'b0, ref_reg[4:0]});
    endproperty
    a_tap_small: assert property (p_tap_small)
        else $error("small ladder level wrong");

endmodule
`default_nettype wire

// ===== bench/cc_comparator_control_test.sv
// Self-checking bench for the comparator control block, all variants
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module cc_comparator_control_test;
    import cc_pkg::*;
    logic pclk, presetn, penable, pwrite, sleep_active;
    logic [2:0] psel;
    logic [7:0] paddr;
    logic [31:0] pwdata, r, d;
    logic [1:0] cmp_raw;
    logic [31:0] rd[3], got[3];
    logic rdy[3], err[3], flg[3], wk[3];
    logic [1:0] res[3];
    cc_ana_s ana[3];
    int num_errors, checks, v;
    int seed = 32'had51efe2;
    int cfg[3], rf[3], eres[3], eflg[3], wexp[3], wcnt[3];
    int cmask[3] = '{32'h05F, 32'h3FF, 32'h3BF};
    int rmask[3] = '{32'h0AF, 32'h0AF, 32'h09F};

    // One instance per variant; selects kept apart so each gets own data
    for (genvar gv = 0; gv < 3; gv++) begin : g
        cc_comparator_control #(.VARIANT(cc_variant_e'(gv))) dut (
            .pclk(pclk), .presetn(presetn), .psel(psel[gv]),
            .penable(penable), .pwrite(pwrite), .paddr(paddr),
            .pwdata(pwdata), .prdata(rd[gv]), .pready(rdy[gv]),
            .pslverr(err[gv]), .cmp_raw(cmp_raw),
            .sleep_active(sleep_active), .ana_ctrl(ana[gv]),
            .cmp_result(res[gv]), .change_flag(flg[gv]),
            .wake_req(wk[gv]));
    end

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Wake pulses last one cycle, so count them at every edge
    always @(posedge pclk) begin
        for (int i = 0; i < 3; i++) if (wk[i] === 1'b1) wcnt[i]++;
    end

    task automatic apb(input logic [2:0] s, input logic w,
            input logic [7:0] a, input logic [31:0] dat);
        logic bad;
        bad = a > 8'h0C || a[1:0] != 2'h0;
        psel <= s;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!(rdy[0] === 1'b1 && rdy[1] === 1'b1 && rdy[2] === 1'b1))
            @(posedge pclk);
        for (int i = 0; i < 3; i++) begin
            got[i] = rd[i];
            if (s[i]) `CHK(err[i], bad)
        end
        psel <= 3'h0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic cc_src_e src(logic internal, logic fixed);
        return internal ? (fixed ? CC_SRC_FIXED : CC_SRC_LADDER) : CC_SRC_PIN;
    endfunction

    // Expected analogue bundle from the modelled registers
    function automatic cc_ana_s xana(int i);
        cc_ana_s a;
        logic [31:0] c, f;
        c = cfg[i];
        f = rf[i];
        a.cmp1_enable = c[0] | (i == 0 && c[1]);
        a.cmp2_enable = c[1];
        a.cmp1_src = src(i == 2 || c[6], i != 0 && c[8]);
        a.cmp2_src = src(i == 0 ? c[6] : c[7], i != 0 && c[9]);
        a.ladder_enable = f[7];
        a.ladder_short = i == 2 || f[5];
        a.ladder_tap = i == 2 ? f[4:0] : {1'b0, f[3:0]};
        a.ladder_level = {1'b0, a.ladder_tap}
            + ((i < 2 && !f[5]) ? 6'h08 : 6'h00);
        a.fixed_mv = i == 0 ? 11'h000 : i == 1 ? 11'h4B0 : 11'h400;
        return a;
    endfunction

    // Model update after settling, then compare pins and registers
    task automatic check_all();
        logic [31:0] c;
        logic [1:0] n, wt;
        for (int i = 0; i < 3; i++) begin
            c = cfg[i];
            n[0] = (c[0] | (i == 0 && c[1])) & (cmp_raw[0] ^ c[2]);
            n[1] = c[1] & (cmp_raw[1] ^ c[3]);
            wt = i == 0 ? {2{c[4]}} : c[5:4];
            if ((wt & (n ^ eres[i][1:0])) != 2'h0) begin
                eflg[i] = 1;
                if (sleep_active) wexp[i]++;
            end
            eres[i] = n;
            `CHK(res[i], n)
            `CHK(flg[i], eflg[i][0])
            `CHK(wcnt[i], wexp[i])
            `CHK(ana[i], xana(i))
        end
        for (int k = 0; k < 4; k++) begin
            apb(3'h7, 1'b0, 8'(4 * k), 32'h0);
            for (int i = 0; i < 3; i++)
                `CHK(got[i], 32'(k == 0 ? cfg[i] : k == 1 ? rf[i] : k == 2 ? eres[i] : eflg[i]))
        end
    endtask

    task automatic results();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        results();
    end

    initial begin
        presetn = 1'b0;
        psel = 3'h0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cmp_raw = 2'h0; // Pins settled before any config
        sleep_active = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_all();
        $display("reset test done");
        // Random mix of writes, input changes, clears and sleep
        for (int k = 0; k < 80; k++) begin
            r = $random(seed);
            d = $random(seed);
            v = r % 3;
            case (r[7:4] % 5)
                0: begin
                    if (v == 0) d = d & 32'hFFFFFF5F;
                    if (v == 2) d[6] = 1'b1;
                    apb(3'(1 << v), 1'b1, CC_OFS_CONFIG, d);
                    cfg[v] = d & cmask[v];
                end
                1: begin
                    apb(3'(1 << v), 1'b1, CC_OFS_REF, d);
                    rf[v] = d & rmask[v];
                end
                2: begin
                    cmp_raw <= d[1:0];
                    @(posedge pclk);
                end
                3: begin
                    apb(3'h7, 1'b1, CC_OFS_FLAG, d);
                    if (d[0]) eflg = '{0, 0, 0};
                end
                default: begin
                    sleep_active <= d[0];
                    @(posedge pclk);
                end
            endcase
            repeat (6) @(posedge pclk);
            check_all();
        end
        $display("random test done");
        // Unmapped place and read-only result must change nothing
        apb(3'h7, 1'b1, 8'h10, 32'hFFFFFFFF);
        apb(3'h7, 1'b0, 8'h10, 32'h0);
        for (int i = 0; i < 3; i++) `CHK(got[i], 32'h0)
        apb(3'h7, 1'b1, CC_OFS_RESULT, 32'hFFFFFFFF);
        repeat (6) @(posedge pclk);
        check_all();
        $display("refusal test done");
        results();
    end
endmodule
`default_nettype wire
